// *** rtl/fsh_hs_if.sv ***
// Carrier between the top and one request handshake unit
`timescale 1ns/1ns
interface fsh_hs_if;
   logic req;      // Synchronised request level
   logic start_ok; // Work may start now
   logic skip;     // Acknowledge without starting work
   logic ok;       // Work finished well, pulse
   logic fail;     // Work failed, pulse
   logic start;    // Start pulse to the application
   logic ack;      // Acknowledge level
   modport unit(input req, start_ok, skip, ok, fail, output start, ack);
   modport ctl(output req, start_ok, skip, ok, fail, input start, ack);
endinterface

// *** rtl/fsh_hs_unit.sv ***
// Set-and-hold handshake for one request bit
`timescale 1ns/1ns
module fsh_hs_unit
   import fsh_pkg::*;
#(
   parameter bit ACK_ON_FAIL = 1'b1
) (
   input wire logic mclk_in,
   input wire logic nrst_in,
   fsh_hs_if.unit hs
);
   fsh_state_t state_r, state_nxt;
   logic req_d_r, req_d_nxt;
   logic rise;

   // ****************************************
   // Edge detect and state step
   // ****************************************
   // Edge from the held level, so a request left high starts nothing more
   assign rise = hs.req & ~req_d_r;
   assign hs.start = (state_r == FSH_IDLE) & rise & hs.start_ok & ~hs.skip;
   assign hs.ack = (state_r == FSH_ACK);

   always_comb begin
      state_nxt = state_r;
      req_d_nxt = hs.req;
      case (state_r)
         FSH_IDLE: begin
            // Skipped edge is acknowledged at once with no work started
            if (rise & hs.skip) begin
               state_nxt = FSH_ACK;
            end else if (rise & hs.start_ok) begin
               state_nxt = FSH_BUSY;
            end
         end
         FSH_BUSY: begin
            // Completion may arrive any number of cycles later
            if (hs.ok) begin
               state_nxt = FSH_ACK;
            end else if (hs.fail) begin
               state_nxt = ACK_ON_FAIL ? FSH_ACK : FSH_IDLE;
            end
         end
         FSH_ACK: begin
            if (!hs.req) begin
               state_nxt = FSH_IDLE;
            end
         end
         default: state_nxt = FSH_IDLE;
      endcase
   end

   // Registers only
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         state_r <= FSH_IDLE;
         req_d_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         req_d_r <= req_d_nxt;
      end
   end
endmodule

// *** rtl/fsh_pkg.sv ***
// Constants and types shared by the status handshake block
// Overview of operation
// - Ready flag, status bit 0, is 1 while a new trigger can be taken.
// - Ready flag mirrors the internal ready level as fast as possible.
// - Trigger acknowledge, bit 2, sets once a trigger is accepted; here it sets only after trig_done_in, never after trig_fail_in.
// - Trigger acknowledge clears when the controller clears its trigger bit.
// - A trigger that is not executed leaves its acknowledge low.
// - Job-switch acknowledge, bit 3, sets on completion, success or failure.
// - Job-switch acknowledge clears as soon as its request bit clears.
// - Job-switch outcome: error code 2 on failure, current job byte.
// - Job-switch acknowledge may come late; the controller waits.
// - Run-entry acknowledge, bit 4, sets when run-entry completes.
// - Run-entry acknowledge clears as soon as its request bit clears.
// - Run-entry outcome: error code 3 on failure, operating-state flag.
// - Run-entry acknowledge only after tool gone and job reloaded, or failure.
// - Job switch starts on rising request bit using control byte 2 index.
// - Job index is binary 1-255; zero causes no job change.
package fsh_pkg;
   // ****************************************
   // Status byte 0 layout
   // ****************************************
   localparam int unsigned FSH_BIT_READY = 0;
   localparam int unsigned FSH_BIT_TRIG_ACK = 2;
   localparam int unsigned FSH_BIT_JOB_ACK = 3;
   localparam int unsigned FSH_BIT_RUN_ACK = 4;
   // Control byte 0 request bit positions
   localparam int unsigned FSH_BIT_TRIG_REQ = 2;
   localparam int unsigned FSH_BIT_JOB_REQ = 3;
   localparam int unsigned FSH_BIT_RUN_REQ = 4;
   localparam logic [7:0] FSH_STATUS_RST = 8'h00;
   // ****************************************
   // Error codes and reset values
   // ****************************************
   localparam logic [7:0] FSH_ERR_NONE = 8'h00;
   localparam logic [7:0] FSH_ERR_JOB = 8'h02;
   localparam logic [7:0] FSH_ERR_RUN = 8'h03;
   localparam logic [7:0] FSH_JOB_NONE = 8'h00;
   localparam logic [7:0] FSH_JOB_RST = 8'h01;
   // Handshake unit states
   typedef enum logic [1:0] {
      FSH_IDLE,
      FSH_BUSY,
      FSH_ACK
   } fsh_state_t;
endpackage

// *** rtl/fsh_status_top.sv ***
// Status flag generator answering the fieldbus control image
`timescale 1ns/1ns
module fsh_status_top
   import fsh_pkg::*;
(
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [7:0] ctrl_flags_in,
   input wire logic [7:0] ctrl_job_in,
   input wire logic ready_level_in,
   input wire logic trig_done_in,
   input wire logic trig_fail_in,
   input wire logic job_done_in,
   input wire logic job_fail_in,
   input wire logic run_done_in,
   input wire logic run_fail_in,
   output logic [7:0] status_flags_out,
   output logic [7:0] err_code_out,
   output logic [7:0] cur_job_out,
   output logic op_state_out,
   output logic trig_start_out,
   output logic job_start_out,
   output logic [7:0] job_index_out,
   output logic run_start_out
);
   logic [7:0] flags_s1_r, flags_s2_r, job_s1_r, job_s2_r;
   logic rdy_s1_r, rdy_s2_r;
   logic [7:0] status_r, status_nxt;
   logic [7:0] err_r, err_nxt, cur_r, cur_nxt, idx_r, idx_nxt;
   logic op_r, op_nxt;
   logic job_busy_r, job_busy_nxt, run_busy_r, run_busy_nxt;

   fsh_hs_if trig_hs();
   fsh_hs_if job_hs();
   fsh_hs_if run_hs();

   // ****************************************
   // Input synchronisers
   // ****************************************
   // Control image and ready come from outside; second stage feeds logic
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         flags_s1_r <= FSH_STATUS_RST;
         flags_s2_r <= FSH_STATUS_RST;
         job_s1_r <= FSH_JOB_NONE;
         job_s2_r <= FSH_JOB_NONE;
         rdy_s1_r <= 1'b0;
         rdy_s2_r <= 1'b0;
      end else begin
         flags_s1_r <= ctrl_flags_in;
         flags_s2_r <= flags_s1_r;
         job_s1_r <= ctrl_job_in;
         job_s2_r <= job_s1_r;
         rdy_s1_r <= ready_level_in;
         rdy_s2_r <= rdy_s1_r;
      end
   end

   // ****************************************
   // Handshake units
   // ****************************************
   // Trigger only starts while ready; an unexecuted one gets no ack
   assign trig_hs.req = flags_s2_r[FSH_BIT_TRIG_REQ];
   assign trig_hs.start_ok = rdy_s2_r;
   assign trig_hs.skip = 1'b0;
   assign trig_hs.ok = trig_done_in;
   assign trig_hs.fail = trig_fail_in;

   // Job index zero acknowledges at once with no job change
   assign job_hs.req = flags_s2_r[FSH_BIT_JOB_REQ];
   assign job_hs.start_ok = 1'b1;
   assign job_hs.skip = (job_s2_r == FSH_JOB_NONE);
   assign job_hs.ok = job_done_in;
   assign job_hs.fail = job_fail_in;

   // Done comes from the application once the job is reloaded
   assign run_hs.req = flags_s2_r[FSH_BIT_RUN_REQ];
   assign run_hs.start_ok = 1'b1;
   assign run_hs.skip = 1'b0;
   assign run_hs.ok = run_done_in;
   assign run_hs.fail = run_fail_in;

   fsh_hs_unit #(.ACK_ON_FAIL(1'b0)) u_trig (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .hs(trig_hs)
   );
   fsh_hs_unit #(.ACK_ON_FAIL(1'b1)) u_job (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .hs(job_hs)
   );
   fsh_hs_unit #(.ACK_ON_FAIL(1'b1)) u_run (
      .mclk_in(mclk_in),
      .nrst_in(nrst_in),
      .hs(run_hs)
   );

   // Start strobes are handshake outputs, so combinational is fine
   assign trig_start_out = trig_hs.start;
   assign job_start_out = job_hs.start;
   assign run_start_out = run_hs.start;

   // ****************************************
   // Status image next values
   // ****************************************
   always_comb begin
      status_nxt = FSH_STATUS_RST;
      status_nxt[FSH_BIT_READY] = rdy_s2_r;
      status_nxt[FSH_BIT_TRIG_ACK] = trig_hs.ack;
      status_nxt[FSH_BIT_JOB_ACK] = job_hs.ack;
      status_nxt[FSH_BIT_RUN_ACK] = run_hs.ack;
      err_nxt = err_r;
      cur_nxt = cur_r;
      op_nxt = op_r;
      idx_nxt = idx_r;
      job_busy_nxt = job_busy_r;
      run_busy_nxt = run_busy_r;
      // Index is frozen at start so a changing byte 2 cannot corrupt it
      if (job_hs.start) begin
         idx_nxt = job_s2_r;
         job_busy_nxt = 1'b1;
      end
      if (run_hs.start) begin
         run_busy_nxt = 1'b1;
      end
      // Outcome only while busy; a stray pulse in idle must not move cur_job
      if (job_busy_r & job_hs.ok) begin
         cur_nxt = idx_r;
         err_nxt = FSH_ERR_NONE;
         job_busy_nxt = 1'b0;
      end else if (job_busy_r & job_hs.fail) begin
         err_nxt = FSH_ERR_JOB;
         job_busy_nxt = 1'b0;
      end
      if (run_busy_r & run_hs.ok) begin
         op_nxt = 1'b1;
         err_nxt = FSH_ERR_NONE;
         run_busy_nxt = 1'b0;
      end else if (run_busy_r & run_hs.fail) begin
         op_nxt = 1'b0;
         err_nxt = FSH_ERR_RUN;
         run_busy_nxt = 1'b0;
      end
   end

   // Registers only; all status outputs come from flip-flops
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         status_r <= FSH_STATUS_RST;
         err_r <= FSH_ERR_NONE;
         cur_r <= FSH_JOB_RST;
         op_r <= 1'b0;
         idx_r <= FSH_JOB_NONE;
         job_busy_r <= 1'b0;
         run_busy_r <= 1'b0;
      end else begin
         status_r <= status_nxt;
         err_r <= err_nxt;
         cur_r <= cur_nxt;
         op_r <= op_nxt;
         idx_r <= idx_nxt;
         job_busy_r <= job_busy_nxt;
         run_busy_r <= run_busy_nxt;
      end
   end

   assign status_flags_out = status_r;
   assign err_code_out = err_r;
   assign cur_job_out = cur_r;
   assign op_state_out = op_r;
   assign job_index_out = idx_r;
endmodule

// *** verification/fsh_plc_model.sv ***
// Controller model that owns the request bits of control byte 0
`timescale 1ns/1ns
module fsh_plc_model (
   input wire logic mclk_in,
   input wire logic [2:0] go_in,
   input wire logic drop_in,
   input wire logic [7:0] status_in,
   output logic [7:0] ctrl_out
);
   initial ctrl_out = 8'h00;
   // Never keyed to ready, which says nothing about results
   always @(posedge mclk_in) begin
      for (int i = 0; i < 3; i++) begin
         if (go_in[i]) begin
            ctrl_out[i + 2] <= 1'b1;
         end else if (status_in[i + 2] || drop_in) begin
            ctrl_out[i + 2] <= 1'b0;
         end
      end
   end
endmodule

// *** verification/fsh_status_handshake_tb_top.sv ***
// Self-checking bench for the status handshake top
`timescale 1ns/1ns
module fsh_status_handshake_tb_top;
   import fsh_pkg::*;
   logic mclk_in = 1'b0;
   logic nrst_in = 1'b0;
   logic ready_r = 1'b0;
   logic drop_r = 1'b0;
   logic [2:0] go_r = 3'h0;
   logic [5:0] app_r = 6'h00; // Done/fail pairs: trig, job, run
   logic [7:0] ctrl_job = 8'h00;
   logic [7:0] ctrl, status, err, cur_job, job_idx, obs;
   logic op_state, trig_st, job_st, run_st;
   int err_count = 0;
   int n_tests = 0;
   int cyc = 0;
   int n_start = 0;
   assign obs = {run_st, job_st, trig_st, status[4:0]};
   fsh_status_top u_dut (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .ctrl_flags_in(ctrl), .ctrl_job_in(ctrl_job), .ready_level_in(ready_r),
      .trig_done_in(app_r[0]), .trig_fail_in(app_r[1]),
      .job_done_in(app_r[2]), .job_fail_in(app_r[3]),
      .run_done_in(app_r[4]), .run_fail_in(app_r[5]),
      .status_flags_out(status), .err_code_out(err), .cur_job_out(cur_job),
      .op_state_out(op_state), .trig_start_out(trig_st),
      .job_start_out(job_st), .job_index_out(job_idx), .run_start_out(run_st));
   fsh_plc_model u_plc (.mclk_in(mclk_in), .go_in(go_r), .drop_in(drop_r),
      .status_in(status), .ctrl_out(ctrl));
   always #5 mclk_in = ~mclk_in;
   // Hang guard; the whole run needs well under a thousand cycles
   always @(posedge mclk_in) begin
      cyc++;
      n_start += trig_st + job_st + run_st;
      if (cyc == 5000) begin
         err_count++;
         report_and_stop();
      end
   end
   task automatic report_and_stop;
      if (err_count == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_in);
   endtask
   // Bounded wait on one observed bit
   task automatic wait_obs(input int i, input logic v);
      for (int k = 0; k < 60 && obs[i] !== v; k++) @(posedge mclk_in);
      check({7'h00, obs[i]}, {7'h00, v});
   endtask
   task automatic go(input int i);
      go_r[i] <= 1'b1;
      tick(1);
      go_r <= 3'h0;
   endtask
   task automatic pulse(input int i);
      app_r[i] <= 1'b1;
      tick(1);
      app_r <= 6'h00;
   endtask
   task automatic drop;
      drop_r <= 1'b1;
      tick(1);
      drop_r <= 1'b0;
      tick(8);
   endtask
   // Job switch; a late completion must still be acknowledged
   task automatic job_case(input logic [7:0] idx, input int f,
      input logic [7:0] e, input logic [7:0] c);
      ctrl_job <= idx;
      tick(3);
      go(1);
      if (idx != 8'h00) begin
         wait_obs(6, 1'b1);
         tick(20);
         check(job_idx, idx);
         pulse(2 + f);
      end
      wait_obs(3, 1'b1);
      check(err, e);
      check(cur_job, c);
      wait_obs(3, 1'b0);
   endtask
   task automatic run_case(input int f, input logic [7:0] e, input logic o);
      go(2);
      wait_obs(7, 1'b1);
      tick(6);
      pulse(4 + f);
      wait_obs(4, 1'b1);
      check(err, e);
      check({7'h00, op_state}, {7'h00, o});
      wait_obs(4, 1'b0);
   endtask
   initial begin
      int k;
      tick(10);
      nrst_in <= 1'b1;
      tick(1);
      check(status, FSH_STATUS_RST);
      check(cur_job, FSH_JOB_RST);
      ready_r <= 1'b1;
      wait_obs(0, 1'b1);
      go(0);
      wait_obs(5, 1'b1);
      pulse(0);
      wait_obs(2, 1'b1);
      wait_obs(2, 1'b0);
      go(0);
      wait_obs(5, 1'b1);
      pulse(1);
      tick(10);
      check(status, 8'h01);
      drop();
      // Edge while not ready is consumed; holding high starts nothing
      ready_r <= 1'b0;
      tick(6);
      k = n_start;
      go(0);
      tick(8);
      ready_r <= 1'b1;
      tick(8);
      check(n_start[7:0], k[7:0]);
      check(status, 8'h01);
      drop();
      job_case(8'haa, 0, FSH_ERR_NONE, 8'haa);
      job_case(8'h05, 1, FSH_ERR_JOB, 8'haa);
      job_case(8'h00, 0, FSH_ERR_JOB, 8'haa);
      run_case(1, FSH_ERR_RUN, 1'b0);
      run_case(0, FSH_ERR_NONE, 1'b1);
      // Stray completion with no job switch under way is ignored
      pulse(2);
      tick(4);
      check(cur_job, 8'haa);
      check(err, FSH_ERR_NONE);
      report_and_stop();
   end
endmodule

// *** verification/fsh_status_props.sv ***
// Port checker for the status handshake top
`timescale 1ns/1ns
module fsh_status_props (
   input wire logic mclk_in,
   input wire logic nrst_in,
   input wire logic [7:0] ctrl_flags_in,
   input wire logic [7:0] ctrl_job_in,
   input wire logic ready_level_in,
   input wire logic trig_done_in,
   input wire logic run_done_in,
   input wire logic run_fail_in,
   input wire logic [7:0] status_flags_out,
   input wire logic trig_start_out,
   input wire logic job_start_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);
   // Reset is checked with the disable switched off
   chk_reset_clears: assert property (disable iff (1'b0)
      !nrst_in |=> status_flags_out == 8'h00) else $error("flags not reset");
   chk_reserved_zero: assert property (
      status_flags_out[7:5] == 3'h0 && !status_flags_out[1])
      else $error("reserved bit set");
   // Four cycles cover two sync stages plus the status register
   chk_ready_high: assert property (
      ready_level_in [*4] |-> status_flags_out[0]) else $error("ready low");
   chk_ready_low: assert property (
      !ready_level_in [*4] |-> !status_flags_out[0]) else $error("ready high");
   chk_trig_drop: assert property (
      !ctrl_flags_in[2] [*6] |-> !status_flags_out[2]) else $error("trig ack");
   chk_job_drop: assert property (
      !ctrl_flags_in[3] [*6] |-> !status_flags_out[3]) else $error("job ack");
   chk_run_drop: assert property (
      !ctrl_flags_in[4] [*6] |-> !status_flags_out[4]) else $error("run ack");
   chk_trig_cause: assert property (
      $rose(status_flags_out[2]) |-> $past(trig_done_in, 2))
      else $error("trig ack without accept");
   chk_run_cause: assert property (
      $rose(status_flags_out[4]) |-> $past(run_done_in, 2) ||
      $past(run_fail_in, 2)) else $error("run ack without outcome");
   chk_start_edge: assert property (
      trig_start_out && $past(nrst_in, 3) |-> $past(ctrl_flags_in[2], 2) &&
      !$past(ctrl_flags_in[2], 3)) else $error("start without edge");
   chk_job_nonzero: assert property (
      job_start_out |-> $past(ctrl_job_in, 2) != 8'h00)
      else $error("job start on index zero");
   cover property (status_flags_out[3]);
   cover property (trig_start_out);
   cover property ($rose(status_flags_out[4]));
endmodule
bind fsh_status_top fsh_status_props u_props (.*);
